// ===== hw/power_button_interrupts.v
// Power button event status, mask and interrupt pin with AXI4-Lite access.
// Assumes button input synchronous to aclk at 40 MHz; host services irq_out_n.
`timescale 1ns/1ps
`default_nettype none
`include "button_irq_consts.vh"

// Operation
// - Press debounced low sets press flag
// - Debounced release also sets press flag
// - Held over one second sets bit 1
// - Held over two seconds sets bit 2
// - Held over three seconds sets bit 3
// - Held over four seconds sets bit 4
// - Held over eight seconds sets bit 5
// - Flags reset zero, stick until cleared
// - Read or write one clears flag
// - Unmasked set flag pulls interrupt low
// - Masks reset to one, flags latch
// - Masks map flags; bits 7:6 unused
// - Debounced state change fires press flag
module power_button_interrupts #(
  parameter integer MS_CYCLES = `CLK_HZ / 1000,      // Cycles per ms
  parameter integer DEB_TICK_CYCLES = `DEB_TICK_CYC  // Cycles per debounce tick
) (
  input wire aclk,                // System clock, 40 MHz
  input wire aresetn,             // Synchronous reset, active low
  input wire power_button_in,     // Button, low when pressed
  output reg irq_out_n,           // Interrupt, active low
  input wire [11:0] s_axi_awaddr, // Write address
  input wire s_axi_awvalid,       // Write address valid
  output reg s_axi_awready,       // Write address ready
  input wire [31:0] s_axi_wdata,  // Write data
  input wire [3:0] s_axi_wstrb,   // Write strobes
  input wire s_axi_wvalid,        // Write data valid
  output reg s_axi_wready,        // Write data ready
  output reg [1:0] s_axi_bresp,   // Write response
  output reg s_axi_bvalid,        // Write response valid
  input wire s_axi_bready,        // Write response ready
  input wire [11:0] s_axi_araddr, // Read address
  input wire s_axi_arvalid,       // Read address valid
  output reg s_axi_arready,       // Read address ready
  output reg [31:0] s_axi_rdata,  // Read data
  output reg [1:0] s_axi_rresp,   // Read response
  output reg s_axi_rvalid,        // Read data valid
  input wire s_axi_rready         // Read data ready
);

  // Word address compare helper for the register decode
  // Only the word part counts, so byte offsets inside a register alias it
  function is_reg;
    input [11:0] addr;
    input [11:0] reg_addr;
    begin
      is_reg = (addr[11:2] == reg_addr[11:2]);
    end
  endfunction

  // Hold time in ms as a count of millisecond strobes
  function [31:0] ms_to_count;
    input [31:0] ms;
    begin
      ms_to_count = ms;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////
  // State
  reg [5:0] status_q;          // Sticky event flags
  reg [5:0] mask_q;            // Event masks, 1 blocks the pin
  reg [7:0] fall_deb_q;        // Press debounce ticks
  reg [7:0] rise_deb_q;        // Release debounce ticks
  reg pressed_prev_q;          // Debounced level, one cycle late
  reg [31:0] ms_div_q;         // Millisecond prescaler
  reg ms_tick_q;               // Millisecond strobe
  // Write address and data may arrive in either order; each is held
  // until both are present, then one response covers the pair
  reg [11:0] aw_addr_q;        // Latched write address
  reg aw_have_q;               // Write address held
  reg [31:0] w_data_q;         // Latched write data
  reg [3:0] w_strb_q;          // Latched write strobes
  reg w_have_q;                // Write data held
  wire debounced_button_state; // Debounced pressed level
  wire [13:0] held_ms;         // Milliseconds held
  reg [5:0] set_vec;           // Events this cycle
  reg [5:0] clr_vec;           // Clears this cycle
  reg [31:0] rd_word;          // Read mux
  reg rd_ok;                   // Read address mapped
  wire wr_go;                  // Write commits this cycle
  wire rd_go;                  // Read taken this cycle

  //////////////////////////////////////////////////////////////////////
  // Debouncer and hold timer
  // The debounced level is the sense bit and the source of press events
  button_debounce u_debounce (
    .aclk(aclk),
    .aresetn(aresetn),
    .button_n(power_button_in),
    .fall_ticks(fall_deb_q),
    .rise_ticks(rise_deb_q),
    .tick_cycles(DEB_TICK_CYCLES),
    .pressed_q(debounced_button_state)
  );

  hold_timer u_hold (
    .aclk(aclk),
    .aresetn(aresetn),
    .pressed(debounced_button_state),
    .ms_tick(ms_tick_q),
    .held_ms_q(held_ms)
  );

  //////////////////////////////////////////////////////////////////////
  // Millisecond strobe; free-running so hold times stay accurate
  // Its phase is arbitrary against a press, so a hold event may land up
  // to one millisecond late; far below what a user can notice
  always @(posedge aclk) begin
    if (!aresetn) begin
      ms_div_q <= 32'h0;
      ms_tick_q <= 1'b0;
    end else if (ms_div_q >= MS_CYCLES - 1) begin
      ms_div_q <= 32'h0;
      ms_tick_q <= 1'b1;
    end else begin
      ms_div_q <= ms_div_q + 32'h1;
      ms_tick_q <= 1'b0;
    end
  end

  // Previous debounced level for edge detection
  always @(posedge aclk) begin
    if (!aresetn) begin
      pressed_prev_q <= 1'b0;
    end else begin
      pressed_prev_q <= debounced_button_state;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Event detection; hold events fire once, when the count crosses
  // Hold events are blocked while released so a stale count never fires
  always @* begin
    set_vec = 6'h00;
    // Press edge, and release edge after a qualified press
    set_vec[`BIT_PRESS] = debounced_button_state != pressed_prev_q;
    // Strictly more than the hold time: fire on the tick after it
    set_vec[`BIT_HOLD1] = ms_tick_q && held_ms == ms_to_count(`HOLD1_MS);
    set_vec[`BIT_HOLD2] = ms_tick_q && held_ms == ms_to_count(`HOLD2_MS);
    set_vec[`BIT_HOLD3] = ms_tick_q && held_ms == ms_to_count(`HOLD3_MS);
    set_vec[`BIT_HOLD4] = ms_tick_q && held_ms == ms_to_count(`HOLD4_MS);
    set_vec[`BIT_HOLD8] = ms_tick_q && held_ms == ms_to_count(`HOLD8_MS);
    if (!debounced_button_state) begin
      set_vec[`EVENT_BITS-1:1] = 5'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel: address and data in either order
  // Readies pulse for one cycle and rest for one, so a master that is
  // slow to raise valid only waits; it never sees a stale acceptance
  assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 12'h000;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      s_axi_awready <= !aw_have_q && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_have_q && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (is_reg(aw_addr_q, `STATUS_ADDR) || is_reg(aw_addr_q, `MASK_ADDR) ||
                        is_reg(aw_addr_q, `SENSE_ADDR) ||
                        is_reg(aw_addr_q, `DEBOUNCE_ADDR)) ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel
  // Read data is registered at the address handshake, so the word that
  // is returned is exactly the one the read-clear below acts on
  assign rd_go = s_axi_arvalid && s_axi_arready;

  always @* begin
    rd_word = 32'h0;
    rd_ok = 1'b1;
    if (is_reg(s_axi_araddr, `STATUS_ADDR)) begin
      rd_word = {26'h0, status_q};
    end else if (is_reg(s_axi_araddr, `MASK_ADDR)) begin
      rd_word = {26'h0, mask_q};
    end else if (is_reg(s_axi_araddr, `SENSE_ADDR)) begin
      // Hold sense bits follow the held time, cleared on release
      rd_word = {26'h0,
                 held_ms > ms_to_count(`HOLD8_MS),
                 held_ms > ms_to_count(`HOLD4_MS),
                 held_ms > ms_to_count(`HOLD3_MS),
                 held_ms > ms_to_count(`HOLD2_MS),
                 held_ms > ms_to_count(`HOLD1_MS),
                 debounced_button_state};
    end else if (is_reg(s_axi_araddr, `DEBOUNCE_ADDR)) begin
      rd_word = {16'h0, rise_deb_q, fall_deb_q};
    end else begin
      rd_ok = 1'b0;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (rd_go) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Clears: a status read clears what it returned; writing one clears
  // A read whose data is never consumed still clears; hosts must take it
  always @* begin
    clr_vec = 6'h00;
    if (rd_go && is_reg(s_axi_araddr, `STATUS_ADDR)) begin
      clr_vec = status_q;
    end
    if (wr_go && is_reg(aw_addr_q, `STATUS_ADDR) && w_strb_q[0]) begin
      clr_vec = clr_vec | w_data_q[5:0];
    end
  end

  // Status flags; a set in the clear cycle wins
  // Writing zero leaves a flag alone; only ones in the low byte clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= `STATUS_RESET;
    end else begin
      status_q <= (status_q & ~clr_vec) | set_vec;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Mask and debounce configuration registers
  // Mask takes only the low byte lane; upper bits of the word are dropped
  always @(posedge aclk) begin
    if (!aresetn) begin
      mask_q <= `MASK_RESET;
      fall_deb_q <= `FALL_DEB_RESET;
      rise_deb_q <= `RISE_DEB_RESET;
    end else if (wr_go) begin
      if (is_reg(aw_addr_q, `MASK_ADDR) && w_strb_q[0]) begin
        mask_q <= w_data_q[5:0];
      end
      if (is_reg(aw_addr_q, `DEBOUNCE_ADDR)) begin
        if (w_strb_q[0]) begin
          fall_deb_q <= w_data_q[7:0];
        end
        if (w_strb_q[1]) begin
          rise_deb_q <= w_data_q[15:8];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Interrupt pin: low while any unmasked flag is set
  // Registered so the pin never glitches while flags and masks move;
  // the cost is one cycle of delay after a flag sets
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_out_n <= 1'b1;
    end else begin
      irq_out_n <= ~|(status_q & ~mask_q);
    end
  end

endmodule
`default_nettype wire

// ===== common/button_irq_consts.vh
// Constants for the power button event and mask logic.
// Assumes a 40 MHz aclk and register indices laid out four bytes apart.
`ifndef BUTTON_IRQ_CONSTS_VH
`define BUTTON_IRQ_CONSTS_VH

// Register indices; byte address is index times four
`define STATUS_INDEX 8'h24
`define MASK_INDEX 8'h25
`define SENSE_INDEX 8'h26
`define DEBOUNCE_INDEX 8'h27
`define STATUS_ADDR 12'h090
`define MASK_ADDR 12'h094
`define SENSE_ADDR 12'h098
`define DEBOUNCE_ADDR 12'h09c

// Field positions
`define BIT_PRESS 0
`define BIT_HOLD1 1
`define BIT_HOLD2 2
`define BIT_HOLD3 3
`define BIT_HOLD4 4
`define BIT_HOLD8 5
`define EVENT_BITS 6

// Reset values
`define STATUS_RESET 6'h00
`define MASK_RESET 6'h3f
`define FALL_DEB_RESET 8'h10
`define RISE_DEB_RESET 8'h10

// Timing: clock rate and hold times in milliseconds
`define CLK_HZ 40000000
`define HOLD1_MS 1000
`define HOLD2_MS 2000
`define HOLD3_MS 3000
`define HOLD4_MS 4000
`define HOLD8_MS 8000
`define DEB_TICK_US 100
`define DEB_TICK_CYC ((`CLK_HZ / 1000000) * `DEB_TICK_US)

`endif

// ===== hw/button_debounce.v
// Debounces the active-low button input into a clean pressed level.
// Assumes the input is synchronous to aclk; intervals come in ticks.
`timescale 1ns/1ps
`default_nettype none
`include "button_irq_consts.vh"

module button_debounce (
  input wire aclk,                // System clock
  input wire aresetn,             // Synchronous reset, active low
  input wire button_n,            // Raw button, low when pressed
  input wire [7:0] fall_ticks,    // Press debounce in ticks
  input wire [7:0] rise_ticks,    // Release debounce in ticks
  input wire [31:0] tick_cycles,  // Cycles per debounce tick
  output reg pressed_q            // Debounced pressed level
);

  reg [31:0] pre_q;  // Tick prescaler
  reg [7:0] cnt_q;   // Ticks the raw level has disagreed

  //////////////////////////////////////////////////////////////////////
  // Count ticks while the raw level differs from the debounced one
  always @(posedge aclk) begin
    if (!aresetn) begin
      pre_q <= 32'h0;
      cnt_q <= 8'h00;
      pressed_q <= 1'b0;
    end else if ((!button_n) == pressed_q) begin
      // Level agrees: restart so a bounce never accumulates
      pre_q <= 32'h0;
      cnt_q <= 8'h00;
    end else if (pre_q >= tick_cycles - 32'h1) begin
      pre_q <= 32'h0;
      if (cnt_q >= (pressed_q ? rise_ticks : fall_ticks)) begin
        pressed_q <= ~pressed_q;
        cnt_q <= 8'h00;
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
    end else begin
      pre_q <= pre_q + 32'h1;
    end
  end

endmodule
`default_nettype wire

// ===== hw/hold_timer.v
// Measures how long the debounced button has been held pressed.
// Assumes a millisecond strobe from the parent; restarts on release.
`timescale 1ns/1ps
`default_nettype none
`include "button_irq_consts.vh"

module hold_timer (
  input wire aclk,            // System clock
  input wire aresetn,         // Synchronous reset, active low
  input wire pressed,         // Debounced pressed level
  input wire ms_tick,         // One pulse each millisecond
  output reg [13:0] held_ms_q // Milliseconds held, saturating
);

  //////////////////////////////////////////////////////////////////////
  // Count while pressed, clear on release
  always @(posedge aclk) begin
    if (!aresetn) begin
      held_ms_q <= 14'h0000;
    end else if (!pressed) begin
      held_ms_q <= 14'h0000;
    end else if (ms_tick && held_ms_q != 14'h3fff) begin
      held_ms_q <= held_ms_q + 14'h0001;
    end
  end

endmodule
`default_nettype wire

// ===== testbench/button_irq_props.sv
// Checker for the power button event block, bound to its top module.
// Assumes both write channels are taken at one edge, as the slave offers.
`timescale 1ns/1ps
`default_nettype none
`include "button_irq_consts.vh"
module button_irq_props (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset, active low
  input wire logic irq_out_n, // Interrupt pin
  input wire logic [11:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  input wire logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic s_axi_wvalid, // Write data valid
  input wire logic s_axi_wready, // Write data ready
  input wire logic s_axi_bvalid, // Response valid
  input wire logic s_axi_bready, // Response ready
  input wire logic [11:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  input wire logic s_axi_arready, // Read address ready
  input wire logic [31:0] s_axi_rdata, // Read data
  input wire logic s_axi_rvalid // Read data valid
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [11:0] rd_addr_q; // Address of the read in flight
  logic [5:0] mask_q; // Shadow of the mask register
  ////////////////////////////////////////
  // Shadow state, so checks need no view inside the block
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_addr_q <= 12'h000;
      mask_q <= `MASK_RESET;
    end else begin
      if (s_axi_arvalid && s_axi_arready) rd_addr_q <= s_axi_araddr;
      if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
          && s_axi_awaddr == `MASK_ADDR) mask_q <= s_axi_wdata[5:0];
    end
  end
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  ////////////////////////////////////////
  // Pin, readback and response checks; four cycles of margin cover the mask write latency
  irq_reset_idle_a: assert property ($rose(aresetn) |-> irq_out_n)
    else $error("interrupt low right after reset");
  mask_quiet_a: assert property ((mask_q == `MASK_RESET) [*4] |-> irq_out_n)
    else $error("interrupt low while all events masked");
  irq_unmasked_a: assert property ($rose(s_axi_rvalid) && rd_addr_q == `STATUS_ADDR
    && |(s_axi_rdata[5:0] & ~mask_q) |-> !irq_out_n)
    else $error("unmasked event read back but interrupt high");
  upper_zero_a: assert property (s_axi_rvalid && rd_addr_q[11:3] == 9'h012
    |-> s_axi_rdata[31:6] == 26'h0)
    else $error("unused status or mask bits read nonzero");
  mask_readback_a: assert property (s_axi_rvalid && rd_addr_q == `MASK_ADDR
    |-> s_axi_rdata[5:0] == mask_q)
    else $error("mask read differs from last write");
  wr_answer_a: assert property (wr_take |-> ##2 s_axi_bvalid)
    else $error("write response late");
  rd_answer_a: assert property (rd_take |-> ##1 s_axi_rvalid)
    else $error("read data late");
  resp_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
endmodule
bind power_button_interrupts button_irq_props props_u (
  .aclk(aclk),
  .aresetn(aresetn),
  .irq_out_n(irq_out_n),
  .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid)
);
`default_nettype wire

// ===== testbench/button_model.sv
// Button as a user presses it, level changes just after a clock edge.
// Assumes the bench calls push and lift between its own bus cycles.
`timescale 1ns/1ps
`default_nettype none
module button_model (
  input wire logic aclk, // System clock
  output logic power_button_in // Low while pressed
);
  initial power_button_in = 1'b1; // Released at start
  ////////////////////////////////////////
  // No bounce modelled; short glitches come from the bench timing instead
  task automatic push;
    @(posedge aclk);
    power_button_in <= 1'b0;
  endtask
  task automatic lift;
    @(posedge aclk);
    power_button_in <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ===== testbench/tb.sv
// Bench for the power button event block: scenario tasks over AXI4-Lite.
// Assumes a 40 MHz clock and shortened ms and debounce tick counts.
`timescale 1ns/1ps
`default_nettype none
`include "button_irq_consts.vh"
module tb;
  logic aclk, aresetn, power_button_in, irq_out_n; // Clock, reset, pins
  logic [11:0] s_axi_awaddr, s_axi_araddr; // Addresses
  logic [31:0] s_axi_wdata, s_axi_rdata; // Data
  logic [3:0] s_axi_wstrb; // Strobes
  logic [1:0] s_axi_bresp, s_axi_rresp; // Responses
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready; // Write side
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready; // Response, read
  logic s_axi_rvalid, s_axi_rready; // Read data
  int error_cnt, compares, cyc_cnt; // Tallies
  // Short counts keep the eight second hold near 32k cycles
  power_button_interrupts #(.MS_CYCLES(4), .DEB_TICK_CYCLES(2)) dut_u (
    .aclk(aclk),
    .aresetn(aresetn),
    .power_button_in(power_button_in),
    .irq_out_n(irq_out_n),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
  );
  button_model btn_u (.aclk(aclk), .power_button_in(power_button_in));
  always #12.5 aclk = ~aclk;
  // Hang guard
  always @(posedge aclk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 50000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////
  task automatic tally_and_finish;
    if (error_cnt == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    while (!s_axi_bvalid) @(posedge aclk);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'h0, {30'h0, s_axi_bresp});
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm,
                    input logic [1:0] er = 2'b00);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(nm, e, s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask
  ////////////////////////////////////////
  task automatic t_regs;
    chk("irq_out_n", 32'h1, {31'h0, irq_out_n});
    rd(`STATUS_ADDR, 32'h0, "status");
    rd(`MASK_ADDR, 32'h3f, "mask");
    rd(`DEBOUNCE_ADDR, {16'h0, `RISE_DEB_RESET, `FALL_DEB_RESET}, "debounce");
    wr(`MASK_ADDR, 32'hffff_ffc0);
    rd(`MASK_ADDR, 32'h0, "mask");
    wr(`MASK_ADDR, 32'hffff_ffff);
    rd(`MASK_ADDR, 32'h3f, "mask");
    rd(12'h0a0, 32'h0, "unmapped", 2'b10);
  endtask
  // Press, release, then a glitch shorter than the press debounce
  task automatic t_press;
    btn_u.push();
    wait_cyc(100);
    rd(`STATUS_ADDR, 32'h1, "status");
    rd(`STATUS_ADDR, 32'h0, "status");
    btn_u.lift();
    wait_cyc(60);
    rd(`STATUS_ADDR, 32'h1, "status");
    btn_u.push();
    wait_cyc(10);
    btn_u.lift();
    wait_cyc(60);
    rd(`STATUS_ADDR, 32'h0, "status");
  endtask
  task automatic t_mask;
    wr(`MASK_ADDR, 32'h3e);
    btn_u.push();
    wait_cyc(100);
    chk("irq_out_n", 32'h0, {31'h0, irq_out_n});
    rd(`STATUS_ADDR, 32'h1, "status");
    wait_cyc(3);
    chk("irq_out_n", 32'h1, {31'h0, irq_out_n});
    btn_u.lift();
    wait_cyc(60);
    wr(`STATUS_ADDR, 32'h0);
    wait_cyc(3);
    chk("irq_out_n", 32'h0, {31'h0, irq_out_n});
    wr(`STATUS_ADDR, 32'h1);
    wait_cyc(3);
    chk("irq_out_n", 32'h1, {31'h0, irq_out_n});
    wr(`MASK_ADDR, 32'h3f);
    btn_u.push();
    wait_cyc(100);
    chk("irq_out_n", 32'h1, {31'h0, irq_out_n});
    rd(`STATUS_ADDR, 32'h1, "status");
  endtask
  task automatic t_hold;
    wait_cyc(3900);
    rd(`STATUS_ADDR, 32'h0, "status");
    wait_cyc(300);
    rd(`STATUS_ADDR, 32'h2, "status");
    wait_cyc(28000);
    rd(`STATUS_ADDR, 32'h3c, "status");
    btn_u.lift();
    wait_cyc(60);
    rd(`STATUS_ADDR, 32'h1, "status");
    btn_u.push();
    wait_cyc(4200);
    rd(`STATUS_ADDR, 32'h3, "status");
    rd(`SENSE_ADDR, 32'h3, "sense");
  endtask
  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 26'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    {error_cnt, compares, cyc_cnt} = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    wait_cyc(2);
    t_regs();
    t_press();
    t_mask();
    t_hold();
    tally_and_finish();
  end
endmodule
`default_nettype wire
